// >>> src/scu_baud.sv
// scu_baud: prescaler and bit rate generator producing one tick per bit period
`timescale 1ns/100ps
module scu_baud
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] clock_source_select,
  input  wire logic [7:0] divisor,
  input  wire logic       restart,
  output logic            bit_tick
);

  typedef struct packed {
    logic [5:0] pre;
    logic [7:0] cnt;
    logic       tick;
  } scu_baud_s;

  scu_baud_s st_reg;
  scu_baud_s st_next;
  logic [5:0] pre_lim;

  // ---------------------------------------------------------------
  // prescale select and bit period count
  // ---------------------------------------------------------------
  always_comb
  begin
    case (clock_source_select) // divide by 1, 4, 16, 64 [R15]
      2'h0:    pre_lim = scu_pkg::PRE_DIV1;
      2'h1:    pre_lim = scu_pkg::PRE_DIV4;
      2'h2:    pre_lim = scu_pkg::PRE_DIV16;
      default: pre_lim = scu_pkg::PRE_DIV64;
    endcase
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (restart)
    begin
      // realign so a new frame gets a full first period
      st_next.pre = 6'h00;
      st_next.cnt = 8'h00;
    end
    else if (st_reg.pre >= pre_lim)
    begin
      st_next.pre = 6'h00;
      if (st_reg.cnt >= divisor) // one bit per generated period [R16]
      begin
        st_next.cnt = 8'h00;
        st_next.tick = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
    else
    begin
      st_next.pre = st_reg.pre + 6'h01;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bit_tick = st_reg.tick;

endmodule // scu_baud

// >>> src/scu_pkg.sv
// scu_pkg: shared constants and carrier types for the serial communication unit
package scu_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE   = 8'h00; // mode: stop length, clock source, sync mode
  localparam logic [7:0] ADDR_BRR    = 8'h04; // bit rate divisor
  localparam logic [7:0] ADDR_TDATA  = 8'h08; // transmit holding register
  localparam logic [7:0] ADDR_RDATA  = 8'h0C; // receive holding register
  localparam logic [7:0] ADDR_STATUS = 8'h10; // serial status register
  localparam logic [7:0] ADDR_MASK   = 8'h14; // interrupt mask

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_STOP_BIT  = 3;   // stop length select
  localparam int MODE_RSVD_BIT  = 2;   // reserved, reads zero
  localparam int MODE_SYNC_BIT  = 7;   // clocked synchronous mode
  localparam int MODE_PAR_EN    = 5;   // parity enable
  localparam int MODE_PAR_ODD   = 4;   // odd parity
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BRR_RESET  = 8'hFF;
  localparam logic [5:0] MASK_RESET = 6'h00;

  // status bits: tx empty, tx end, rx full, overrun, framing, parity
  localparam int ST_TXE = 0;
  localparam int ST_TEND = 1;
  localparam int ST_RXF = 2;
  localparam int ST_ORUN = 3;
  localparam int ST_FRM = 4;
  localparam int ST_PAR = 5;
  localparam int ST_W = 6;
  localparam logic [5:0] STATUS_RESET = 6'h03;

  // prescale divide counts for clock source codes 00..11
  localparam logic [5:0] PRE_DIV1  = 6'h00;
  localparam logic [5:0] PRE_DIV4  = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0F;
  localparam logic [5:0] PRE_DIV64 = 6'h3F;

  // bit period is (divisor+1) prescaled ticks; rx samples once per bit tick
  localparam int DATA_BITS = 8;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       sync_mode;
    logic       two_stop;
    logic       par_en;
    logic       par_odd;
  } scu_frame_s;

  typedef struct packed {
    logic       done;      // character finished
    logic [7:0] data;
    logic       frame_err;
    logic       par_err;
  } scu_rx_s;

endpackage

// >>> src/scu_rx.sv
// scu_rx: receive shifter sampling the line once per bit tick
`timescale 1ns/100ps
module scu_rx
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              bit_tick,
  input  wire logic              rxd,
  input  wire scu_pkg::scu_frame_s frame,
  output scu_pkg::scu_rx_s       rx_out
);

  typedef enum {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} scu_rxst_e;

  typedef struct packed {
    scu_rxst_e        fsm;
    logic [7:0]       shreg;   // receive shift register
    logic [2:0]       idx;
    logic             par;
    scu_pkg::scu_rx_s out;
  } scu_rxstate_s;

  scu_rxstate_s st_reg;
  scu_rxstate_s st_next;

  // ---------------------------------------------------------------
  // receive sequence; sampling at bit ticks keeps this simple at the
  // cost of tolerance to rate mismatch
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.out.done = 1'b0;
    if (bit_tick)
    begin
      case (st_reg.fsm)
        RX_IDLE:
        begin
          // a low second stop position lands here as the next start [R12]
          if (!rxd)
          begin
            st_next.fsm = RX_DATA;
            st_next.idx = 3'h0;
            st_next.par = frame.par_odd;
          end
        end
        RX_DATA:
        begin
          st_next.shreg = {rxd, st_reg.shreg[7:1]};
          st_next.par = st_reg.par ^ rxd;
          st_next.idx = st_reg.idx + 3'h1;
          if (st_reg.idx == 3'h7)
          begin
            if (frame.sync_mode)
            begin
              // no stop bits in clocked synchronous mode [R10]
              st_next.fsm = RX_IDLE;
              st_next.out.done = 1'b1;
              st_next.out.data = {rxd, st_reg.shreg[7:1]};
              st_next.out.frame_err = 1'b0;
              st_next.out.par_err = 1'b0;
            end
            else
            begin
              st_next.fsm = frame.par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR:
        begin
          st_next.par = st_reg.par ^ rxd;
          st_next.fsm = RX_STOP;
        end
        RX_STOP:
        begin
          // only the first stop bit is checked [R11]
          st_next.fsm = RX_IDLE;
          st_next.out.done = 1'b1;
          st_next.out.data = st_reg.shreg;
          st_next.out.frame_err = !rxd;
          st_next.out.par_err = frame.par_en && st_reg.par;
        end
        default: st_next.fsm = RX_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '{fsm: RX_IDLE, default: '0};
    else
      st_reg <= st_next;
  end

  assign rx_out = st_reg.out;

endmodule // scu_rx

// >>> src/scu_top.sv
// scu_top: serial communication unit with AXI4-Lite registers, transmitter and error flagging
//
// What this block does
// (R01) set transmit empty on holding-to-shift move
// (R02) accept holding writes regardless of empty flag
// (R03) write while not empty overwrites pending character
// (R04) software checks empty flag before each write
// (R05) overrun: character discarded, holding register kept
// (R06) each error flag set independently together
// (R07) overrun cases: full and overrun flags high
// (R08) framing/parity only: character still transferred
// (R09) mode bit 3 selects one/two stops
// (R10) synchronous mode ignores stop length entirely
// (R11) receiver checks only the first stop
// (R12) low second stop starts next character
// (R13) transmit appends one or two high bits
// (R14) mode bit 2 reserved, reads zero
// (R15) clock source divides by 1/4/16/64
// (R16) divisor sets bit period, one bit each
`timescale 1ns/100ps
module scu_top
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxd,
  output logic             txd,
  output logic             irq
);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} scu_txst_e;

  typedef struct packed {
    // bus slave
    logic             aw_held;     // write address captured
    logic [7:0]       aw_addr;
    logic             w_held;      // write data captured
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    // registers
    logic [7:0]       mode;
    logic [7:0]       brr;
    logic [7:0]       tdata;       // transmit holding register
    logic [7:0]       rdata_hold;  // receive holding register
    logic [5:0]       status;      // serial status register
    logic [5:0]       mask;
    // transmitter
    scu_txst_e        tx_fsm;
    logic [7:0]       tx_shift;    // transmit shift register
    logic [2:0]       tx_idx;
    logic             tx_par;
    logic             txd;
  } scu_state_s;

  scu_state_s          st_reg;
  scu_state_s          st_next;
  logic [1:0]          rst_sync;   // reset release synchroniser
  logic                rst_n;      // synchronised reset
  logic                bit_tick;
  scu_pkg::scu_frame_s frame;
  scu_pkg::scu_rx_s    rx_out;
  logic                wr_go;      // both write halves present
  logic                rd_go;
  logic                restart;

  // ---------------------------------------------------------------
  // reset release: asserts at once, releases after two edges
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // frame format seen by the shifters
  assign frame.sync_mode = st_reg.mode[scu_pkg::MODE_SYNC_BIT];
  assign frame.two_stop  = st_reg.mode[scu_pkg::MODE_STOP_BIT];
  assign frame.par_en    = st_reg.mode[scu_pkg::MODE_PAR_EN];
  assign frame.par_odd   = st_reg.mode[scu_pkg::MODE_PAR_ODD];

  // realign the bit clock on a rate or mode write; ticks otherwise run free
  assign restart = wr_go && (st_reg.aw_addr == scu_pkg::ADDR_MODE || st_reg.aw_addr == scu_pkg::ADDR_BRR);

  // ---------------------------------------------------------------
  // baud generator and receiver
  // ---------------------------------------------------------------
  scu_baud u_baud
  (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .clock_source_select (st_reg.mode[1:0]),
    .divisor             (st_reg.brr),
    .restart             (restart),
    .bit_tick            (bit_tick)
  );

  scu_rx u_rx
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bit_tick (bit_tick),
    .rxd      (rxd),
    .frame    (frame),
    .rx_out   (rx_out)
  );

  assign wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  assign rd_go = s_axi_arvalid && !st_reg.rvalid;

  // ---------------------------------------------------------------
  // next state: bus, registers, flags, transmitter
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [5:0] set_bits;
    logic [5:0] clr_bits;
    logic       load_tx;
    set_bits = 6'h00;
    clr_bits = 6'h00;
    load_tx  = 1'b0;
    st_next  = st_reg;

    // write address and data channels, taken in either order
    if (s_axi_awvalid && !st_reg.aw_held)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;

    // register write, low byte lane carries every field
    if (wr_go)
    begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = 2'h0;
      if (st_reg.w_strb[0])
      begin
        case (st_reg.aw_addr)
          scu_pkg::ADDR_MODE:
          begin
            st_next.mode = st_reg.w_data[7:0];
            st_next.mode[scu_pkg::MODE_RSVD_BIT] = 1'b0; // [R14]
            st_next.mode[6] = 1'b0;
          end
          scu_pkg::ADDR_BRR:    st_next.brr = st_reg.w_data[7:0];
          scu_pkg::ADDR_TDATA:
          begin
            // accepted whatever the empty flag; a pending byte is lost [R02] [R03]
            st_next.tdata = st_reg.w_data[7:0];
            clr_bits[scu_pkg::ST_TXE]  = 1'b1;
            clr_bits[scu_pkg::ST_TEND] = 1'b1;
          end
          scu_pkg::ADDR_STATUS: clr_bits = st_reg.w_data[5:0];
          scu_pkg::ADDR_MASK:   st_next.mask = st_reg.w_data[5:0];
          scu_pkg::ADDR_RDATA:  st_next.bresp = 2'h0;
          default:              st_next.bresp = 2'h2;
        endcase
      end
      else if (st_reg.aw_addr > scu_pkg::ADDR_MASK || st_reg.aw_addr[1:0] != 2'h0)
      begin
        st_next.bresp = 2'h2;
      end
    end

    // register read
    if (rd_go)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = 2'h0;
      st_next.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        scu_pkg::ADDR_MODE:   st_next.rdata[7:0] = st_reg.mode;
        scu_pkg::ADDR_BRR:    st_next.rdata[7:0] = st_reg.brr;
        scu_pkg::ADDR_TDATA:  st_next.rdata[7:0] = st_reg.tdata;
        scu_pkg::ADDR_RDATA:  st_next.rdata[7:0] = st_reg.rdata_hold;
        scu_pkg::ADDR_STATUS: st_next.rdata[5:0] = st_reg.status;
        scu_pkg::ADDR_MASK:   st_next.rdata[5:0] = st_reg.mask;
        default:              st_next.rresp = 2'h2;
      endcase
    end

    // received character: errors flagged together, overrun blocks transfer
    if (rx_out.done)
    begin
      set_bits[scu_pkg::ST_FRM] = rx_out.frame_err; // [R06]
      set_bits[scu_pkg::ST_PAR] = rx_out.par_err;   // [R06]
      if (st_reg.status[scu_pkg::ST_RXF])
      begin
        // full stays 1, new character dropped [R05] [R07]
        set_bits[scu_pkg::ST_ORUN] = 1'b1;
      end
      else if (rx_out.frame_err || rx_out.par_err)
      begin
        // transferred but full not raised on error [R08]
        st_next.rdata_hold = rx_out.data;
      end
      else
      begin
        st_next.rdata_hold = rx_out.data;
        set_bits[scu_pkg::ST_RXF] = 1'b1;
      end
    end

    // transmitter sequence, one step per bit tick
    if (bit_tick)
    begin
      case (st_reg.tx_fsm)
        TX_IDLE:
        begin
          st_next.txd = 1'b1;
        end
        TX_START:
        begin
          st_next.txd = st_reg.tx_shift[0];
          st_next.tx_par = st_reg.tx_par ^ st_reg.tx_shift[0];
          st_next.tx_shift = {1'b1, st_reg.tx_shift[7:1]};
          st_next.tx_idx = 3'h1;
          st_next.tx_fsm = TX_DATA;
        end
        TX_DATA:
        begin
          if (st_reg.tx_idx == 3'h0)
          begin
            if (frame.sync_mode)
            begin
              // synchronous: no stop bits, ignore stop length [R10]
              st_next.txd = 1'b1;
              st_next.tx_fsm = TX_IDLE;
              set_bits[scu_pkg::ST_TEND] = st_reg.status[scu_pkg::ST_TXE];
            end
            else if (frame.par_en)
            begin
              st_next.txd = st_reg.tx_par;
              st_next.tx_fsm = TX_PAR;
            end
            else
            begin
              st_next.txd = 1'b1;
              st_next.tx_fsm = TX_STOP1;
            end
          end
          else
          begin
            st_next.txd = st_reg.tx_shift[0];
            st_next.tx_par = st_reg.tx_par ^ st_reg.tx_shift[0];
            st_next.tx_shift = {1'b1, st_reg.tx_shift[7:1]};
            st_next.tx_idx = st_reg.tx_idx + 3'h1;
          end
        end
        TX_PAR:
        begin
          st_next.txd = 1'b1;
          st_next.tx_fsm = TX_STOP1;
        end
        TX_STOP1:
        begin
          // one high bit, or a second one when two stops selected [R09] [R13]
          st_next.txd = 1'b1;
          if (frame.two_stop)
            st_next.tx_fsm = TX_STOP2;
          else
          begin
            st_next.tx_fsm = TX_IDLE;
            set_bits[scu_pkg::ST_TEND] = st_reg.status[scu_pkg::ST_TXE];
          end
        end
        TX_STOP2:
        begin
          st_next.txd = 1'b1;
          st_next.tx_fsm = TX_IDLE;
          set_bits[scu_pkg::ST_TEND] = st_reg.status[scu_pkg::ST_TXE];
        end
        default: st_next.tx_fsm = TX_IDLE;
      endcase
      // next character starts on the tick that ends the last stop bit
      if (st_next.tx_fsm == TX_IDLE && !st_reg.status[scu_pkg::ST_TXE])
        load_tx = 1'b1;
    end

    // move holding to shift, start bit goes out, empty flag set [R01]
    if (load_tx)
    begin
      st_next.tx_shift = st_reg.tdata;
      st_next.tx_par   = frame.par_odd;
      st_next.txd      = 1'b0;
      st_next.tx_fsm   = TX_START;
      set_bits[scu_pkg::ST_TXE] = 1'b1;
    end

    // hardware set beats a same-cycle software clear
    st_next.status = (st_reg.status & ~clr_bits) | set_bits;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg        <= '{tx_fsm: TX_IDLE, default: '0};
      st_reg.mode   <= scu_pkg::MODE_RESET;
      st_reg.brr    <= scu_pkg::BRR_RESET;
      st_reg.status <= scu_pkg::STATUS_RESET;
      st_reg.mask   <= scu_pkg::MASK_RESET;
      st_reg.txd    <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready  = !st_reg.w_held;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign txd           = st_reg.txd;
  assign irq           = |(st_reg.status & st_reg.mask);

endmodule // scu_top

// >>> verif/scu_peer.sv
// scu_peer: remote serial station sending on rxd and decoding txd
`timescale 1ns/100ps
module scu_peer
(
  input  wire logic core_clk,
  input  wire logic txd,
  output logic      rxd
);
  int         parity_flag = 1;      // txd bit period in clocks, set by the bench
  int         cyc = 0;      // running cycle count
  int         k = -1;       // cycles into a txd frame, -1 while idle
  int         st_q[$];      // cycle of each txd start edge
  logic [7:0] d_q[$];       // characters decoded from txd
  logic [7:0] sh = 8'h0;    // data bits gathered so far
  logic       last = 1'h1;  // txd at the previous edge
  initial rxd = 1'h1;       // line rests high between characters
  // --------------------
  // txd decoder: mid-bit sampling, lsb first
  // --------------------
  always @(posedge core_clk)
  begin
    cyc++;
    if (k < 0 && last && !txd)
    begin
      st_q.push_back(cyc);
      k = 0;
    end
    else if (k >= 0) k++;
    if (k >= parity_flag && k < 9 * parity_flag && k % parity_flag == parity_flag / 2) sh = {txd, sh[7:1]};
    // re-arm at the first stop bit so a following start is caught
    if (k == 9 * parity_flag)
    begin
      d_q.push_back(sh);
      k = -1;
    end
    last = txd;
  end
  // one bit per clock, even parity, one stop; a call right after
  // another puts its start in the second stop slot
  task automatic send(input logic [7:0] d, input logic ferr, input logic perr);
    logic [10:0] f;
    f = {~ferr, ^d ^ perr, d, 1'h0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge core_clk);
      rxd <= f[i];
    end
    if (ferr)
    begin
      @(posedge core_clk);
      rxd <= 1'h1;
    end
  endtask
endmodule // scu_peer

// >>> verif/scu_top_sva.sv
// scu_top_sva: port checks on the register bus of the serial unit
`timescale 1ns/100ps
module scu_top_sva
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // --------------------
  // handshake checks
  // --------------------
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  // both halves taken together: held one cycle, answered the next
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write not answered");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mode_reserved: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> s_axi_rdata[2] == 1'h0)
    else $error("reserved mode bit set");
endmodule // scu_top_sva

bind scu_top scu_top_sva u_sva (.*);

// >>> verif/scu_top_tb.sv
// scu_top_tb: self-checking bench for the serial unit
`timescale 1ns/100ps
module scu_top_tb;
  logic        core_clk = 1'h0, rstn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;    // whole words only
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        rxd, txd, irq;
  int          mismatches = 0, check_count = 0, parity_flag;
  logic [31:0] ms, rdat;              // model status and holding byte
  logic [7:0]  a, b, c;
  logic [6:0]  fe = 7'h46, pe = 7'h2C, cl = 7'h1F, pr = 7'h10; // receive table
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  scu_top uut (.*);
  scu_peer peer (.core_clk, .txd, .rxd);
  // --------------------
  // checking and bus tasks
  // --------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 400)
    begin
      mismatches++;
      $display("[ERR] %0t ns: wait ran out", $time);
      conclude();
    end
  endtask
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end
    while (!s_axi_bvalid && n < 400);
    s_axi_bready <= 1'h0;
    tmo(n);
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end
    while (!s_axi_rvalid && n < 400);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    tmo(n);
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ad, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  // status poll spaced one bit period apart, bounded
  task automatic poll(input int k);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (n = 0; n < 400; n++)
    begin
      rd(8'h10, d, r);
      if (d[k] === 1'h1) break;
      repeat (parity_flag) @(posedge core_clk);
    end
    tmo(n);
  endtask
  // --------------------
  // main sequence
  // --------------------
  initial
  begin
    void'($urandom(16055));
    parity_flag = 1;
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge core_clk);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'hFF);
    rc(8'h10, 32'h3);
    rc(8'h14, 32'h0);
    rc(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'h1, 2'h2);
    wr(8'h00, 32'hFF);
    rc(8'h00, 32'hBB);
    // every clock source and stop length, random divisor
    for (int k = 0; k < 8; k++)
    begin
      int br;
      br = $urandom_range(4, 2);
      parity_flag = (br + 1) * (1 << (2 * (k / 2)));
      peer.parity_flag = parity_flag;
      peer.d_q.delete();
      peer.st_q.delete();
      a = $urandom;
      b = ~a;
      c = $urandom;
      wr(8'h04, br);
      wr(8'h00, (k % 2) * 8 + k / 2);
      wr(8'h08, a);
      poll(0);
      wr(8'h08, b);
      rc(8'h10, 32'h0);
      wr(8'h08, c);
      poll(1);
      chk(peer.d_q.size(), 2);
      chk(peer.d_q[0], a);
      chk(peer.d_q[1], c);
      chk(peer.st_q[1] - peer.st_q[0], (10 + k % 2) * parity_flag);
    end
    // receive error table, two stops selected, parity on
    parity_flag = 1;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h28);
    wr(8'h14, 32'h4);
    ms = 32'h3;
    rdat = 32'h0;
    for (int i = 0; i < 7; i++)
    begin
      a = $urandom;
      if (cl[i])
      begin
        wr(8'h10, 32'h3C);
        ms = 32'h3;
      end
      peer.send(a, fe[i], pe[i]);
      if (ms[2]) ms[3] = 1'h1;
      else
      begin
        rdat = a;
        ms[2] = !(fe[i] | pe[i]);
      end
      ms[4] = ms[4] | fe[i];
      ms[5] = ms[5] | pe[i];
      if (!pr[i])
      begin
        repeat (4) @(posedge core_clk);
        rc(8'h10, ms);
        rc(8'h0C, rdat);
        chk(irq, ms[2]);
      end
    end
    // interrupt masked, raised by another bit, then cleared
    wr(8'h14, 32'h0);
    chk(irq, 1'h0);
    wr(8'h14, 32'h8);
    chk(irq, 1'h1);
    wr(8'h10, 32'h3C);
    rc(8'h10, 32'h3);
    chk(irq, 1'h0);
    conclude();
  end
endmodule // scu_top_tb
